// *** hw/dacv_top.sv ***
// command decoder for the pin and vendor widgets of a display-audio codec
`timescale 1ns/10ps
module dacv_top
    import dacv_pkg::*;
(
    input  wire logic        core_clk,         // 20 mhz codec link clock
    input  wire logic        rst_n,            // function-group reset
    input  wire logic        pwr_rst_n,        // power-on reset, low
    input  wire logic        cmd_valid,        // one command this cycle
    input  wire logic [11:0] cmd_verb,         // command code
    input  wire logic [7:0]  cmd_payload,      // eight-bit payload
    input  wire logic        mst_mode,         // transport in multistream
    input  wire logic [31:0] global_timecode,  // running time-code
    input  wire logic [31:0] wall_clock,       // running wall clock
    input  wire logic [15:0] sink_flags,       // sink list flags
    input  wire logic [23:0] mbox_other,       // other config bytes
    output logic             rsp_valid,        // response strobe
    output logic [31:0]      rsp_data,         // response word
    output logic             unsol_valid,      // unsolicited strobe
    output logic [5:0]       unsol_tag,        // tag in unsolicited
    output logic             clock_off,        // clock-off pulse
    output logic [1:0]       frame_send_mode,  // decoded send mode
    output logic             frame_send_pulse, // send-once request
    output logic             multistream_index,// multistream indexing
    output logic             expose_all_widgets,
    output logic [3:0]       port_select,      // port in reduced mode
    output logic [4:0]       unsol_subtag      // protection subtag
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic set_fidx, set_fdata, set_fsend, set_prot, set_cmap, set_dpick;
    logic set_sid, set_mbox, set_unsol, set_vctl, set_trig, set_tpipe;
    logic set_ofs, set_clkoff;
    assign set_fidx   = cmd_valid && cmd_verb == CMD_FIDX_SET;
    assign set_fdata  = cmd_valid && cmd_verb == CMD_FDATA_SET;
    assign set_fsend  = cmd_valid && cmd_verb == CMD_FSEND_SET;
    assign set_prot   = cmd_valid && cmd_verb == CMD_PROT_SET;
    assign set_cmap   = cmd_valid && cmd_verb == CMD_CMAP_SET;
    assign set_dpick  = cmd_valid && cmd_verb == CMD_DPICK_SET;
    assign set_sid    = cmd_valid && cmd_verb == CMD_SID_SET;
    assign set_mbox   = cmd_valid && cmd_verb == CMD_MBOX_SET;
    assign set_unsol  = cmd_valid && cmd_verb == CMD_UNSOL_SET;
    assign set_vctl   = cmd_valid && cmd_verb == CMD_VCTL_SET;
    assign set_trig   = cmd_valid && cmd_verb == CMD_TRIG_SET;
    assign set_tpipe  = cmd_valid && cmd_verb == CMD_TPIPE_SET;
    assign set_clkoff = cmd_valid && cmd_verb == CMD_CLKOFF_SET;
    // offset byte commands form a contiguous block of four
    assign set_ofs    = cmd_valid && cmd_verb >= CMD_OFS_B0_SET
                        && cmd_verb <= CMD_OFS_B3_SET;

    // ------------------------------------------------------------
    // infoframe index, buffer and send control
    // ------------------------------------------------------------
    logic [7:0] fidx_q;                         // packet and byte offset
    logic [7:0] frame_mem [FRAME_BYTES];        // infoframe buffer
    logic [1:0] fsend_mem [FRAME_BYTES >> PKT_LSB]; // per-packet mode
    logic [2:0] pkt_sel;                        // current packet

    assign pkt_sel = fidx_q[7:PKT_LSB];

    // index register: packet select above, byte offset below
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fidx_q <= BYTE_RST;
        end else if (set_fidx) begin
            fidx_q <= cmd_payload;
        end
    end

    // buffer byte at current index; memory has no reset by design
    always_ff @(posedge core_clk) begin
        if (set_fdata) begin
            frame_mem[fidx_q] <= cmd_payload;
        end
    end

    // send mode per packet; low payload bits are reserved and the
    // reserved code keeps the stored mode, as the decoded mode does
    always_ff @(posedge core_clk) begin
        if (set_fsend && cmd_payload[7:6] != SEND_RESERVED) begin
            fsend_mem[pkt_sel] <= cmd_payload[7:6];
        end
    end

    // decoded send controls for the indexed frame
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_send_mode  <= SEND_OFF;
            frame_send_pulse <= 1'b0;
        end else begin
            frame_send_pulse <= 1'b0;
            if (set_fsend) begin
                unique case (dacv_send_t'(cmd_payload[7:6]))
                    SEND_OFF:      frame_send_mode <= SEND_OFF;
                    // reserved code leaves the mode as it stands
                    SEND_RESERVED: frame_send_mode <= frame_send_mode;
                    SEND_ONCE: begin
                        frame_send_mode  <= SEND_ONCE;
                        frame_send_pulse <= 1'b1;
                    end
                    SEND_REPEAT:   frame_send_mode <= SEND_REPEAT;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // protection subtag, channel map, device pick
    // ------------------------------------------------------------
    logic [7:0] cmap_q;    // channel high nibble, slot low nibble
    logic [5:0] dpick_q;   // multistream entry index

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            unsol_subtag <= 5'h00;
        end else if (set_prot) begin
            unsol_subtag <= cmd_payload[7:SUBTAG_LSB];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmap_q <= BYTE_RST;
        end else if (set_cmap) begin
            cmap_q <= cmd_payload;
        end
    end

    // host keeps this to 0..3; stored as written
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dpick_q <= 6'h00;
        end else if (set_dpick) begin
            dpick_q <= cmd_payload[5:0];
        end
    end

    // ------------------------------------------------------------
    // stream identifiers
    // ------------------------------------------------------------
    logic [4:0] sid_q [SID_COUNT];   // low five bits of each identifier
    logic [2:0] sid_idx_q;           // last programmed index

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sid_idx_q <= 3'h0;
            for (int i = 0; i < SID_COUNT; i++) begin
                sid_q[i] <= 5'h00;
            end
        end else if (set_sid) begin
            sid_idx_q <= cmd_payload[2:0];
            sid_q[cmd_payload[2:0]] <= cmd_payload[7:SUBTAG_LSB];
        end
    end

    // ------------------------------------------------------------
    // mailbox and its unsolicited response
    // ------------------------------------------------------------
    logic [7:0] mbox_q;       // mailbox byte
    logic [7:0] unsol_ctl_q;  // allow bit and tag

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mbox_q <= BYTE_RST;
        end else if (set_mbox) begin
            mbox_q <= cmd_payload;
        end
    end

    // bit 6 is reserved and never stored
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            unsol_ctl_q <= BYTE_RST;
        end else if (set_unsol) begin
            unsol_ctl_q <= {cmd_payload[7], 1'b0, cmd_payload[5:0]};
        end
    end

    // a mailbox write raises one response when allowed
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            unsol_valid <= 1'b0;
            unsol_tag   <= 6'h00;
        end else begin
            unsol_valid <= set_mbox && unsol_ctl_q[UNSOL_EN_BIT];
            unsol_tag   <= unsol_ctl_q[5:0];
        end
    end

    // clock-off acts on every receipt, payload unused
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_off <= 1'b0;
        end else begin
            clock_off <= set_clkoff;
        end
    end

    // ------------------------------------------------------------
    // vendor control byte; only the power-on reset clears it
    // ------------------------------------------------------------
    logic [7:0] vctl_q;

    // single and double group resets leave it alone, so drivers keep
    // the port choice across a codec restart
    always_ff @(posedge core_clk or negedge pwr_rst_n) begin
        if (!pwr_rst_n) begin
            vctl_q <= BYTE_RST;
        end else if (set_vctl) begin
            vctl_q <= {cmd_payload[7:HI_NIB_LSB], 2'b00,
                       cmd_payload[1:0]};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            expose_all_widgets <= 1'b0;
            port_select        <= 4'h0;
            multistream_index  <= 1'b0;
        end else begin
            expose_all_widgets <= vctl_q[VC_ALL_BIT];
            port_select        <= vctl_q[7:HI_NIB_LSB];
            multistream_index  <= mst_mode && vctl_q[VC_MST_BIT];
        end
    end

    // ------------------------------------------------------------
    // time-code capture, offset, pipe index
    // ------------------------------------------------------------
    logic [31:0] tc_cap_q;
    logic [31:0] wc_cap_q;
    logic [31:0] ofs_q;
    logic [5:0]  tpipe_q;
    logic [1:0]  ofs_lane;

    // both values sampled on the same edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tc_cap_q <= WORD_RST;
            wc_cap_q <= WORD_RST;
        end else if (set_trig) begin
            tc_cap_q <= global_timecode;
            wc_cap_q <= wall_clock;
        end
    end

    assign ofs_lane = 2'(cmd_verb - CMD_OFS_B0_SET);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ofs_q <= WORD_RST;
        end else if (set_ofs) begin
            ofs_q[ofs_lane*BYTE_W +: BYTE_W] <= cmd_payload;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tpipe_q <= 6'h00;
        end else if (set_tpipe) begin
            tpipe_q <= cmd_payload[5:0];
        end
    end

    // ------------------------------------------------------------
    // get responses: one word, next cycle, in arrival order
    // ------------------------------------------------------------
    logic        is_get;
    logic [31:0] rsp_d;

    always_comb begin
        is_get = 1'b1;
        rsp_d  = WORD_RST;
        unique case (cmd_verb)
            CMD_PARAM_GET:
                if (cmd_payload == PARAM_WIDGET_CAPS) begin
                    rsp_d[CAPS_TYPE_LSB +: 4] = WIDGET_TYPE_VEND;
                end
            CMD_STATUS_GET: rsp_d = WORD_RST;
            CMD_UNSOL_GET:  rsp_d[7:0] = unsol_ctl_q;
            CMD_FIDX_GET:   rsp_d[7:0] = fidx_q;
            CMD_FDATA_GET:  rsp_d[7:0] = frame_mem[fidx_q];
            CMD_FSEND_GET:  rsp_d[7:6] = fsend_mem[pkt_sel];
            CMD_CMAP_GET:   rsp_d[7:0] = cmap_q;
            CMD_DPICK_GET: begin
                // sink id follows the pipe of the picked entry
                rsp_d[SINK_ID_LSB +: 6] = dpick_q;
                rsp_d[5:0]              = dpick_q;
            end
            CMD_SLIST_GET:  rsp_d[15:0] = sink_flags & 16'h7777;
            CMD_SID_GET:    rsp_d[7:0] = {sid_q[sid_idx_q], sid_idx_q};
            CMD_MBOX_GET: begin
                rsp_d[31:24]             = mbox_other[23:16];
                rsp_d[MBOX_LSB +: BYTE_W] = mbox_q;
                rsp_d[15:0]              = mbox_other[15:0];
            end
            CMD_VCTL_GET:   rsp_d[7:0] = vctl_q;
            CMD_TC_GET:     rsp_d = tc_cap_q;
            CMD_WC_GET:     rsp_d = wc_cap_q;
            CMD_OFS_GET:    rsp_d = ofs_q;
            CMD_TPIPE_GET:  rsp_d[5:0] = tpipe_q;
            default:        is_get = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_data  <= WORD_RST;
        end else begin
            rsp_valid <= cmd_valid && is_get;
            if (cmd_valid && is_get) begin
                rsp_data <= rsp_d;
            end
        end
    end

endmodule

// *** hw/dacv_pkg.sv ***
// constants and types for the display-audio codec command decoder
package dacv_pkg;

    // ------------------------------------------------------------
    // command codes (12-bit verb)
    // ------------------------------------------------------------
    localparam logic [11:0] CMD_PARAM_GET     = 12'hf00;
    localparam logic [11:0] CMD_STATUS_GET    = 12'hf80;
    localparam logic [11:0] CMD_UNSOL_SET     = 12'h708;
    localparam logic [11:0] CMD_UNSOL_GET     = 12'hf08;
    localparam logic [11:0] CMD_FIDX_SET      = 12'h730;
    localparam logic [11:0] CMD_FIDX_GET      = 12'hf30;
    localparam logic [11:0] CMD_FDATA_SET     = 12'h731;
    localparam logic [11:0] CMD_FDATA_GET     = 12'hf31;
    localparam logic [11:0] CMD_FSEND_SET     = 12'h732;
    localparam logic [11:0] CMD_FSEND_GET     = 12'hf32;
    localparam logic [11:0] CMD_PROT_SET      = 12'h733;
    localparam logic [11:0] CMD_CMAP_SET      = 12'h734;
    localparam logic [11:0] CMD_CMAP_GET      = 12'hf34;
    localparam logic [11:0] CMD_DPICK_SET     = 12'h735;
    localparam logic [11:0] CMD_DPICK_GET     = 12'hf35;
    localparam logic [11:0] CMD_SLIST_GET     = 12'hf36;
    localparam logic [11:0] CMD_SID_SET       = 12'h73c;
    localparam logic [11:0] CMD_SID_GET       = 12'hf3c;
    localparam logic [11:0] CMD_MBOX_SET      = 12'h71e;
    localparam logic [11:0] CMD_MBOX_GET      = 12'hf1e;
    localparam logic [11:0] CMD_CLKOFF_SET    = 12'h728;
    localparam logic [11:0] CMD_VCTL_SET      = 12'h781;
    localparam logic [11:0] CMD_VCTL_GET      = 12'hf81;
    localparam logic [11:0] CMD_TRIG_SET      = 12'h782;
    localparam logic [11:0] CMD_TC_GET        = 12'hf83;
    localparam logic [11:0] CMD_WC_GET        = 12'hf84;
    localparam logic [11:0] CMD_OFS_GET       = 12'hf85;
    localparam logic [11:0] CMD_OFS_B0_SET    = 12'h785;
    localparam logic [11:0] CMD_OFS_B3_SET    = 12'h788;
    localparam logic [11:0] CMD_TPIPE_SET     = 12'h789;
    localparam logic [11:0] CMD_TPIPE_GET     = 12'hf89;

    // parameter id and widget capabilities answer
    localparam logic [7:0]  PARAM_WIDGET_CAPS = 8'h09;
    localparam logic [3:0]  WIDGET_TYPE_VEND  = 4'hf;
    localparam int          CAPS_TYPE_LSB     = 20;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int PKT_LSB      = 5;   // packet select in index byte
    localparam int SUBTAG_LSB   = 3;   // subtag and stream tag position
    localparam int HI_NIB_LSB   = 4;   // upper nibble of a payload
    localparam int SINK_ID_LSB  = 6;   // sink id in device report
    localparam int MBOX_LSB     = 16;  // mailbox byte in mailbox get
    localparam int UNSOL_EN_BIT = 7;   // allow bit of unsol control
    localparam int VC_MST_BIT   = 1;   // multistream feature enable
    localparam int VC_ALL_BIT   = 0;   // expose all widgets
    localparam int SID_COUNT    = 8;   // stream identifiers held
    localparam int FRAME_BYTES  = 256; // infoframe buffer depth
    localparam int SINK_COUNT   = 4;   // multistream entries
    localparam int BYTE_W       = 8;

    // reset values
    localparam logic [7:0]  BYTE_RST = 8'h00;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    // frame send modes
    typedef enum logic [1:0] {
        SEND_OFF      = 2'h0,
        SEND_RESERVED = 2'h1,
        SEND_ONCE     = 2'h2,
        SEND_REPEAT   = 2'h3
    } dacv_send_t;

endpackage

// *** tb/dacv_monitor.sv ***
// assertion checker on the ports of the codec command decoder
`timescale 1ns/10ps
module dacv_monitor
    import dacv_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        cmd_valid,
    input wire logic [11:0] cmd_verb,
    input wire logic [7:0]  cmd_payload,
    input wire logic        mst_mode,
    input wire logic [31:0] wall_clock,
    input wire logic        rsp_valid,
    input wire logic [31:0] rsp_data,
    input wire logic        unsol_valid,
    input wire logic        clock_off,
    input wire logic [1:0]  frame_send_mode,
    input wire logic        multistream_index,
    input wire logic [4:0]  unsol_subtag
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic        is_get;      // one of five get verbs checked here, owes one answer
    logic [31:0] wall_held_q; // wall clock seen at the last trigger
    assign is_get = cmd_valid && cmd_verb inside {CMD_PARAM_GET,
        CMD_CMAP_GET, CMD_VCTL_GET, CMD_OFS_GET, CMD_SLIST_GET};
    // own copy of the capture, so the answer is judged from inputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wall_held_q <= 32'h0000_0000;
        end else if (cmd_valid && cmd_verb == CMD_TRIG_SET) begin
            wall_held_q <= wall_clock;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    get_answered_a: assert property (is_get |=> rsp_valid)
        else $error("get left unanswered");
    rsp_cause_a: assert property (
        rsp_valid |-> $past(cmd_valid && cmd_verb[11:8] == 4'hf))
        else $error("answer without a get");
    caps_word_a: assert property (
        (cmd_valid && cmd_verb == CMD_PARAM_GET
        && cmd_payload == PARAM_WIDGET_CAPS) |=> rsp_data == 32'h00f0_0000)
        else $error("wrong widget caps");
    clock_off_a: assert property (
        clock_off == $past(cmd_valid && cmd_verb == CMD_CLKOFF_SET))
        else $error("clock off pulse wrong");
    subtag_a: assert property (
        (cmd_valid && cmd_verb == CMD_PROT_SET)
        |=> unsol_subtag == $past(cmd_payload[7:3]))
        else $error("subtag not stored");
    unsol_cause_a: assert property (
        unsol_valid |-> $past(cmd_valid && cmd_verb == CMD_MBOX_SET))
        else $error("unsolicited without mailbox write");
    mst_gate_a: assert property (!mst_mode |=> !multistream_index)
        else $error("multistream indexing without mode");
    send_mode_a: assert property (
        (cmd_valid && cmd_verb == CMD_FSEND_SET
        && cmd_payload[7:6] != 2'h1)
        |=> frame_send_mode == $past(cmd_payload[7:6]))
        else $error("send mode not decoded");
    wall_read_a: assert property (
        (cmd_valid && cmd_verb == CMD_WC_GET)
        |=> rsp_data == wall_held_q)
        else $error("captured wall clock wrong");
    // main scenarios reached
    cover property (unsol_valid);
    cover property (clock_off);
    cover property (multistream_index);
endmodule

// *** tb/dacv_host_model.sv ***
// model of the audio host controller issuing codec commands
`timescale 1ns/10ps
module dacv_host_model (
    input  wire logic   core_clk,
    output logic        cmd_valid,
    output logic [11:0] cmd_verb,
    output logic [7:0]  cmd_payload
);
    // idle link at time zero
    initial begin
        cmd_valid   = 1'b0;
        cmd_verb    = 12'h000;
        cmd_payload = 8'h00;
    end
    // one command at a time in program order, so an index always
    // lands before the data or offset byte that relies on it
    task automatic send(input logic [11:0] verb,
                        input logic [7:0]  pay);
        @(posedge core_clk);
        cmd_valid   <= 1'b1;
        cmd_verb    <= verb;
        cmd_payload <= pay;
        @(posedge core_clk);
        // released lines show the inverse so stale values never match
        cmd_valid   <= 1'b0;
        cmd_verb    <= ~verb;
        cmd_payload <= ~pay;
        #1;
    endtask
endmodule

// *** tb/dacv_top_test.sv ***
// self-checking bench for the codec command decoder
`timescale 1ns/10ps
module dacv_top_test
    import dacv_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        pwr_rst_n = 1'b0;
    logic        mst_mode = 1'b0;
    logic [31:0] global_timecode = 32'h0000_1000;
    logic [31:0] wall_clock = 32'h0000_0000;
    logic [15:0] sink_flags = 16'hffff;
    logic [23:0] mbox_other = 24'hc3_5a69;
    logic        cmd_valid, rsp_valid, unsol_valid, clock_off;
    logic        frame_send_pulse, multistream_index, expose_all_widgets;
    logic [11:0] cmd_verb;
    logic [7:0]  cmd_payload;
    logic [31:0] rsp_data, exp_wall, exp_gtc;
    logic [5:0]  unsol_tag;
    logic [1:0]  frame_send_mode;
    logic [3:0]  port_select;
    logic [4:0]  unsol_subtag;
    logic [1:0]  send_code [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    logic [1:0]  send_exp  [4] = '{2'h0, 2'h2, 2'h3, 2'h3}; // 01 keeps
    int          mismatches = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    // ------------------------------------------------------------
    // clock, running counters, hang guard
    // ------------------------------------------------------------
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        wall_clock      <= wall_clock + 32'd1;
        global_timecode <= global_timecode + 32'd3;
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            final_report();
        end
    end
    dacv_host_model dacv_host_model_i (.core_clk, .cmd_valid, .cmd_verb,
        .cmd_payload);
    dacv_top dacv_top_i (.core_clk, .rst_n, .pwr_rst_n, .cmd_valid,
        .cmd_verb, .cmd_payload, .mst_mode, .global_timecode, .wall_clock,
        .sink_flags, .mbox_other, .rsp_valid, .rsp_data, .unsol_valid,
        .unsol_tag, .clock_off, .frame_send_mode, .frame_send_pulse,
        .multistream_index, .expose_all_widgets, .port_select,
        .unsol_subtag);
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [11:0] v, input logic [7:0] p);
        dacv_host_model_i.send(v, p);
    endtask
    // answer is registered, so it stands right after the taking edge
    task automatic get(input logic [11:0] v, input logic [7:0] p,
                       input logic [31:0] exp);
        dacv_host_model_i.send(v, p);
        chk({rsp_valid, rsp_data}, {1'b1, exp});
    endtask
    task automatic final_report();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n       <= 1'b1;
        pwr_rst_n   <= 1'b1;
        get(CMD_VCTL_GET, 8'h00, 32'h0);
        get(CMD_CMAP_GET, 8'h00, 32'h0);
        get(CMD_WC_GET, 8'h00, 32'h0);
        get(CMD_TPIPE_GET, 8'h00, 32'h0);
        get(CMD_PARAM_GET, PARAM_WIDGET_CAPS, 32'h00f0_0000);
        get(CMD_PARAM_GET, 8'h0c, 32'h0);
        put(12'hf7f, 8'h00);
        chk(33'(rsp_valid), 33'h0);
        put(CMD_CMAP_SET, 8'ha5);
        get(CMD_CMAP_GET, 8'h00, 32'h0000_00a5);
        // offset bytes loaded high byte first
        for (int i = 3; i >= 0; i--) begin
            put(CMD_OFS_B0_SET + 12'(i), 8'(8'h11 * (i + 1)));
        end
        get(CMD_OFS_GET, 8'h00, 32'h4433_2211);
        put(CMD_TPIPE_SET, 8'hff);
        get(CMD_TPIPE_GET, 8'h00, 32'h0000_003f);
        // counters have moved on once since the taking edge
        put(CMD_TRIG_SET, 8'h5a);
        exp_wall = wall_clock - 32'd1;
        exp_gtc  = global_timecode - 32'd3;
        get(CMD_WC_GET, 8'h00, exp_wall);
        get(CMD_TC_GET, 8'h00, exp_gtc);
        put(CMD_UNSOL_SET, 8'hc5);
        put(CMD_MBOX_SET, 8'h12);
        chk(33'({unsol_valid, unsol_tag}), 33'h45);
        get(CMD_UNSOL_GET, 8'h00, 32'h0000_0085);
        get(CMD_MBOX_GET, 8'h00,
            {mbox_other[23:16], 8'h12, mbox_other[15:0]});
        put(CMD_UNSOL_SET, 8'h05);
        put(CMD_MBOX_SET, 8'h34);
        chk(33'(unsol_valid), 33'h0);
        put(CMD_PROT_SET, 8'hff);
        chk(33'(unsol_subtag), 33'h1f);
        put(CMD_CLKOFF_SET, 8'h5a);
        chk(33'(clock_off), 33'h1);
        put(CMD_DPICK_SET, 8'hc2);
        get(CMD_DPICK_GET, 8'h00, 32'h0000_0082);
        get(CMD_SLIST_GET, 8'h00, 32'h0000_7777);
        put(CMD_SID_SET, 8'hab);
        get(CMD_SID_GET, 8'h00, 32'h0000_00ab);
        // two bytes in two places, then back to the first
        put(CMD_FIDX_SET, 8'h23);
        put(CMD_FDATA_SET, 8'h5c);
        put(CMD_FIDX_SET, 8'h24);
        put(CMD_FDATA_SET, 8'h77);
        put(CMD_FIDX_SET, 8'h23);
        get(CMD_FDATA_GET, 8'h00, 32'h0000_005c);
        for (int i = 0; i < 4; i++) begin
            put(CMD_FSEND_SET, {send_code[i], 6'h3f});
            chk(33'({frame_send_mode, frame_send_pulse}),
                33'({send_exp[i], send_code[i] == 2'h2}));
        end
        // packet 1 keeps repeat, the reserved code left it alone
        get(CMD_FSEND_GET, 8'h00, 32'h0000_00c0);
        get(CMD_FIDX_GET, 8'h00, 32'h0000_0023);
        get(CMD_STATUS_GET, 8'h00, 32'h0);
        put(CMD_VCTL_SET, 8'h8f);
        @(posedge core_clk);
        mst_mode <= 1'b1;
        get(CMD_VCTL_GET, 8'h00, 32'h0000_0083);
        chk(33'({port_select, expose_all_widgets, multistream_index}),
            33'h23);
        // double group reset in mid-run keeps the vendor byte, clears the offset word
        repeat (2) begin
            @(posedge core_clk);
            rst_n <= 1'b0;
            repeat (2) @(posedge core_clk);
            rst_n <= 1'b1;
        end
        get(CMD_VCTL_GET, 8'h00, 32'h0000_0083);
        get(CMD_OFS_GET, 8'h00, 32'h0);
        @(posedge core_clk);
        mst_mode <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(33'(multistream_index), 33'h0);
        // only the power-on reset clears the vendor byte
        @(posedge core_clk);
        pwr_rst_n <= 1'b0;
        @(posedge core_clk);
        pwr_rst_n <= 1'b1;
        get(CMD_VCTL_GET, 8'h00, 32'h0);
        chk(33'({port_select, expose_all_widgets}), 33'h0);
        final_report();
    end
endmodule
bind dacv_top dacv_monitor dacv_monitor_i (.core_clk, .rst_n, .cmd_valid,
    .cmd_verb, .cmd_payload, .mst_mode, .wall_clock, .rsp_valid,
    .rsp_data, .unsol_valid, .clock_off, .frame_send_mode,
    .multistream_index, .unsol_subtag);
